// ---- cfc_cmd_flow.v ----
// command pipeline, queue flushing and register slave of the host command unit
// Operation
// - rising edge of command write enable can raise an interrupt
// - buffered parameters for next command held apart until command change
// - empty input queue stalls the running command, never ends it
// - some commands collect input words before processing them
// - new command ends previous one, flushes queued data, then starts
// - collected amount set by request count or physical block setting
// - write commands take any number of words, end only on next command
// - no-operation command flushes previous data and starts nothing else
// - pixel read and exchange results pushed to output queue as device returns them
// - request count zero gives one single transfer per written word
// - result block moves only when request count plus one words free
// - physical area read sized by own register, no space blocking
// - output queue depth is 64 or 128 words, shown by variant bit
// - output high flag set when fill reaches programmable upper limit
// - after finish and data drained, next command loads, enable sets
// - no-operation activates nothing, moves no data, keeps queued words
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cfc_defs.vh"
module cfc_cmd_flow #(
  parameter CHIP_SMALL = 1
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // axi4-lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // execution device request stream
  output wire        edValid,
  input  wire        edReady,
  output wire [7:0]  edCmd,
  output wire [31:0] edParam,
  output wire [31:0] edData,
  // execution device result stream
  input  wire        resValid,
  input  wire [31:0] resData,
  output wire        resReady,
  // interrupt
  output wire        irq
);

  // ----------------------------------------
  // states and sizes
  // ----------------------------------------
  localparam S_IDLE  = 2'd0;
  localparam S_RUN   = 2'd1;
  localparam S_BURST = 2'd2;
  localparam [7:0] OUT_DEPTH = (CHIP_SMALL != 0) ? `CFC_DEPTH_SMALL : `CFC_DEPTH_BIG;
  localparam [7:0] IN_DEPTH  = OUT_DEPTH;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [1:0]  state_ff;
  reg  [7:0]  cmdPend_ff;
  reg         pendValid_ff;
  reg  [31:0] parPend_ff;
  reg  [7:0]  cmdAct_ff;
  reg  [31:0] parAct_ff;
  reg  [6:0]  reqCnt_ff;
  reg  [6:0]  physBlk_ff;
  reg  [7:0]  upLim_ff;
  reg  [15:0] paLen_ff;
  reg  [15:0] paLeft_ff;
  reg  [7:0]  remain_ff;
  reg  [7:0]  flushLeft_ff;
  reg         edValid_ff;
  reg  [2:0]  irqSt_ff;
  reg  [2:0]  irqMask_ff;
  reg  [2:0]  evtOld_ff;
  reg         awHeld_ff;
  reg  [7:0]  awAddr_ff;
  reg         wHeld_ff;
  reg  [31:0] wData_ff;
  reg  [3:0]  wStrb_ff;
  reg         bValid_ff;
  reg  [1:0]  bResp_ff;
  reg         arPend_ff;
  reg  [7:0]  arAddr_ff;
  reg         rValid_ff;
  reg  [31:0] rData_ff;
  reg  [1:0]  rResp_ff;
  reg  [31:0] rdMux;
  reg         rdOk;
  reg         wrOk;
  integer     i;

  wire [7:0]  inCount;
  wire [7:0]  outCount;
  wire        inFull;
  wire        inEmpty;
  wire        outFull;
  wire        outEmpty;
  wire [31:0] inRd;
  wire [31:0] outRd;
  wire        cwe;
  wire        ofh;
  wire [2:0]  evtNow;
  wire [2:0]  evtRise;
  wire        wrFire;
  wire        arFire;
  wire        cmdWrite;
  wire        inPush;
  wire        outPop;
  wire        irqRdClr;
  wire        isNop;
  wire        isRead;
  wire        isFinite;
  wire        usesPhys;
  wire [7:0]  burstLen;
  wire [7:0]  avail;
  wire [7:0]  take;
  wire        outRoom;
  wire        cntZero;
  wire        issue;
  wire        inPop;

  // ----------------------------------------
  // command classes and flags
  // ----------------------------------------
  assign isNop    = (cmdAct_ff == `CFC_CMD_NOP);
  assign isFinite = (cmdAct_ff == `CFC_CMD_RDPA);
  assign usesPhys = isFinite || (cmdAct_ff == `CFC_CMD_WRPA);
  assign isRead   = isFinite || (cmdAct_ff == `CFC_CMD_RDPIX) || (cmdAct_ff == `CFC_CMD_XCPIX);
  assign cwe      = !pendValid_ff;
  assign ofh      = (outCount >= upLim_ff);
  assign evtNow   = {inEmpty, ofh, cwe};
  assign evtRise  = evtNow & ~evtOld_ff;

  // ----------------------------------------
  // collection and flush sizing
  // ----------------------------------------
  // request count zero still gives a length of one word per transfer
  assign burstLen = usesPhys ? ({1'b0, physBlk_ff} + 8'd1) : ({1'b0, reqCnt_ff} + 8'd1);
  // during a flush only words queued before the new command count
  assign avail    = pendValid_ff ? flushLeft_ff : inCount;
  assign take     = (pendValid_ff && (avail < burstLen)) ? avail : burstLen;
  // reserve a whole block of result space before issuing any of it
  assign outRoom  = !isRead || (({1'b0, outCount} + {1'b0, take}) <= {1'b0, OUT_DEPTH});
  assign cntZero  = isFinite ? (paLeft_ff == 16'h0000) : (remain_ff == 8'h00);
  assign issue    = (state_ff == S_BURST) && !cntZero && (!edValid_ff || edReady);
  assign inPop    = issue && !isFinite;

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  assign s_axi_awready = !awHeld_ff && !bValid_ff;
  assign s_axi_wready  = !wHeld_ff && !bValid_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = !arPend_ff && !rValid_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;
  assign wrFire        = awHeld_ff && wHeld_ff && !bValid_ff;
  assign arFire        = s_axi_arvalid && !arPend_ff && !rValid_ff;
  assign cmdWrite      = wrFire && (awAddr_ff == `CFC_A_CMD) && wStrb_ff[0];
  assign inPush        = wrFire && (awAddr_ff == `CFC_A_INFIFO) && (wStrb_ff == 4'hf);
  assign outPop        = arFire && (s_axi_araddr == `CFC_A_OUTFIFO);
  assign irqRdClr      = arPend_ff && (arAddr_ff == `CFC_A_IRQST);

  // ----------------------------------------
  // execution device side
  // ----------------------------------------
  assign edValid  = edValid_ff;
  assign edCmd    = cmdAct_ff;
  assign edParam  = parAct_ff;
  assign edData   = inRd;
  assign resReady = !outFull;
  assign irq      = |(irqSt_ff & irqMask_ff);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // write map check, read-only and unmapped addresses answer slverr
  always @* begin
    wrOk = 1'b0;
    if (awAddr_ff == `CFC_A_CMD) begin
      wrOk = 1'b1;
    end else if (awAddr_ff == `CFC_A_IRQMSK) begin
      wrOk = 1'b1;
    end else if (awAddr_ff == `CFC_A_REQCNT) begin
      wrOk = 1'b1;
    end else if (awAddr_ff == `CFC_A_PHYSBLK) begin
      wrOk = 1'b1;
    end else if (awAddr_ff == `CFC_A_UPLIM) begin
      wrOk = 1'b1;
    end else if (awAddr_ff == `CFC_A_INFIFO) begin
      wrOk = 1'b1;
    end else if (awAddr_ff == `CFC_A_PARAM) begin
      wrOk = 1'b1;
    end else if (awAddr_ff == `CFC_A_PALEN) begin
      wrOk = 1'b1;
    end
  end

  // read mux on the address held from the previous cycle
  always @* begin
    rdMux = 32'h00000000;
    rdOk  = 1'b1;
    if (arAddr_ff == `CFC_A_CMD) begin
      rdMux = {24'h000000, cmdPend_ff};
    end else if (arAddr_ff == `CFC_A_SHADOW) begin
      rdMux = {24'h000000, cmdAct_ff};
    end else if (arAddr_ff == `CFC_A_FLAGS) begin
      rdMux[`CFC_F_CWE] = cwe;
      rdMux[`CFC_F_IFE] = inEmpty;
      rdMux[`CFC_F_OFH] = ofh;
      rdMux[`CFC_F_OFF] = outFull;
      rdMux[`CFC_F_VAR] = (CHIP_SMALL != 0);
    end else if (arAddr_ff == `CFC_A_IRQST) begin
      rdMux = {29'h00000000, irqSt_ff};
    end else if (arAddr_ff == `CFC_A_IRQMSK) begin
      rdMux = {29'h00000000, irqMask_ff};
    end else if (arAddr_ff == `CFC_A_REQCNT) begin
      rdMux = {25'h0000000, reqCnt_ff};
    end else if (arAddr_ff == `CFC_A_PHYSBLK) begin
      rdMux = {25'h0000000, physBlk_ff};
    end else if (arAddr_ff == `CFC_A_UPLIM) begin
      rdMux = {24'h000000, upLim_ff};
    end else if (arAddr_ff == `CFC_A_INFIFO) begin
      rdMux = 32'h00000000;
    end else if (arAddr_ff == `CFC_A_OUTFIFO) begin
      rdMux = outRd;
    end else if (arAddr_ff == `CFC_A_PARAM) begin
      rdMux = parPend_ff;
    end else if (arAddr_ff == `CFC_A_PALEN) begin
      rdMux = {16'h0000, paLen_ff};
    end else begin
      rdOk = 1'b0;
    end
  end

  // ----------------------------------------
  // bus slave registers
  // ----------------------------------------
  // address and data may arrive in either order, one write at a time
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wHeld_ff  <= 1'b0;
      wData_ff  <= 32'h00000000;
      wStrb_ff  <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff  <= `CFC_RESP_OKAY;
      arPend_ff <= 1'b0;
      arAddr_ff <= 8'h00;
      rValid_ff <= 1'b0;
      rData_ff  <= 32'h00000000;
      rResp_ff  <= `CFC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff  <= wrOk ? `CFC_RESP_OKAY : `CFC_RESP_SLVERR;
      end else if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
      // queue data reaches the read register one cycle after the pop
      if (arFire) begin
        arPend_ff <= 1'b1;
        arAddr_ff <= s_axi_araddr;
      end else if (arPend_ff) begin
        arPend_ff <= 1'b0;
        rValid_ff <= 1'b1;
        rData_ff  <= rdMux;
        rResp_ff  <= rdOk ? `CFC_RESP_OKAY : `CFC_RESP_SLVERR;
      end else if (rValid_ff && s_axi_rready) begin
        rValid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // configuration, command pipeline and interrupts
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_ff     <= S_IDLE;
      cmdPend_ff   <= `CFC_CMD_NOP;
      pendValid_ff <= 1'b0;
      parPend_ff   <= 32'h00000000;
      cmdAct_ff    <= `CFC_CMD_NOP;
      parAct_ff    <= 32'h00000000;
      reqCnt_ff    <= `CFC_RST_REQCNT;
      physBlk_ff   <= `CFC_RST_PHYSBLK;
      upLim_ff     <= `CFC_RST_UPLIM;
      paLen_ff     <= `CFC_RST_PALEN;
      paLeft_ff    <= 16'h0000;
      remain_ff    <= 8'h00;
      flushLeft_ff <= 8'h00;
      edValid_ff   <= 1'b0;
      irqSt_ff     <= 3'h0;
      irqMask_ff   <= 3'h0;
      evtOld_ff    <= 3'h7;
    end else begin
      // software writes; parameters wait here for the command change
      if (wrFire && (awAddr_ff == `CFC_A_PARAM)) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (wStrb_ff[i]) begin
            parPend_ff[i*8 +: 8] <= wData_ff[i*8 +: 8];
          end
        end
      end
      if (wrFire && wStrb_ff[0]) begin
        if (awAddr_ff == `CFC_A_REQCNT) begin
          reqCnt_ff <= wData_ff[6:0];
        end else if (awAddr_ff == `CFC_A_PHYSBLK) begin
          physBlk_ff <= wData_ff[6:0];
        end else if (awAddr_ff == `CFC_A_UPLIM) begin
          upLim_ff <= wData_ff[7:0];
        end else if (awAddr_ff == `CFC_A_IRQMSK) begin
          irqMask_ff <= wData_ff[2:0];
        end else if (awAddr_ff == `CFC_A_PALEN) begin
          paLen_ff[7:0] <= wData_ff[7:0];
        end
      end
      if (wrFire && wStrb_ff[1] && (awAddr_ff == `CFC_A_PALEN)) begin
        paLen_ff[15:8] <= wData_ff[15:8];
      end
      // sticky events, a new event wins over the clearing read
      evtOld_ff <= evtNow;
      irqSt_ff  <= (irqSt_ff & ~(irqRdClr ? 3'h7 : 3'h0)) | evtRise;
      // words queued before the new command belong to the old one
      if (cmdWrite) begin
        cmdPend_ff   <= wData_ff[7:0];
        pendValid_ff <= 1'b1;
        flushLeft_ff <= inCount - {7'h00, inPop};
      end else if (inPop && (flushLeft_ff != 8'h00)) begin
        flushLeft_ff <= flushLeft_ff - 8'd1;
      end
      // request register drops once the device takes the word
      if (issue) begin
        edValid_ff <= 1'b1;
      end else if (edReady) begin
        edValid_ff <= 1'b0;
      end
      case (state_ff)
        S_IDLE: begin
          // command change: pending command and parameters go active
          if (pendValid_ff && !cmdWrite) begin
            cmdAct_ff    <= cmdPend_ff;
            parAct_ff    <= parPend_ff;
            paLeft_ff    <= paLen_ff;
            pendValid_ff <= 1'b0;
            state_ff     <= S_RUN;
          end
        end
        S_RUN: begin
          if (isNop) begin
            state_ff <= S_IDLE;
          end else if (isFinite) begin
            // finite read runs its own length, space check is skipped
            state_ff <= (paLeft_ff == 16'h0000) ? S_IDLE : S_BURST;
          end else if (pendValid_ff && (avail == 8'h00)) begin
            state_ff <= S_IDLE;
          end else if ((avail >= take) && outRoom) begin
            // an empty queue just leaves the command waiting here
            remain_ff <= take;
            state_ff  <= S_BURST;
          end
        end
        S_BURST: begin
          if (issue && isFinite) begin
            paLeft_ff <= paLeft_ff - 16'd1;
          end else if (issue) begin
            remain_ff <= remain_ff - 8'd1;
          end
          if (cntZero && (!edValid_ff || edReady)) begin
            state_ff <= S_RUN;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // queues
  // ----------------------------------------
  cfc_fifo #(.AW(`CFC_AW)) uInQueue (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .depthLimit (IN_DEPTH),
    .pushEn     (inPush),
    .pushData   (wData_ff),
    .popEn      (inPop),
    .popData    (inRd),
    .count      (inCount),
    .full       (inFull),
    .empty      (inEmpty)
  );

  // device results land here as soon as they arrive, flushed or not
  cfc_fifo #(.AW(`CFC_AW)) uOutQueue (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .depthLimit (OUT_DEPTH),
    .pushEn     (resValid),
    .pushData   (resData),
    .popEn      (outPop),
    .popData    (outRd),
    .count      (outCount),
    .full       (outFull),
    .empty      (outEmpty)
  );

endmodule // cfc_cmd_flow

// ---- cfc_defs.vh ----
// constants shared by the command flow controller files
`ifndef CFC_DEFS_VH
`define CFC_DEFS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CFC_A_CMD     8'h00
`define CFC_A_SHADOW  8'h04
`define CFC_A_FLAGS   8'h08
`define CFC_A_IRQST   8'h0c
`define CFC_A_IRQMSK  8'h10
`define CFC_A_REQCNT  8'h14
`define CFC_A_PHYSBLK 8'h18
`define CFC_A_UPLIM   8'h1c
`define CFC_A_INFIFO  8'h20
`define CFC_A_OUTFIFO 8'h24
`define CFC_A_PARAM   8'h28
`define CFC_A_PALEN   8'h2c

// ----------------------------------------
// command codes
// ----------------------------------------
`define CFC_CMD_NOP   8'h00
`define CFC_CMD_RDPIX 8'h01
`define CFC_CMD_XCPIX 8'h02
`define CFC_CMD_RDPA  8'h03
`define CFC_CMD_WRPA  8'h04
`define CFC_CMD_LINE  8'h05

// ----------------------------------------
// flag and interrupt bit positions
// ----------------------------------------
`define CFC_F_CWE  0
`define CFC_F_IFE  1
`define CFC_F_OFH  2
`define CFC_F_OFF  3
`define CFC_F_VAR  4
`define CFC_I_CWE  0
`define CFC_I_OFH  1
`define CFC_I_IFE  2

// ----------------------------------------
// sizes, reset values and bus answers
// ----------------------------------------
`define CFC_AW          7
`define CFC_DEPTH_SMALL 8'd64
`define CFC_DEPTH_BIG   8'd128
`define CFC_RST_REQCNT  7'h00
`define CFC_RST_PHYSBLK 7'h00
`define CFC_RST_UPLIM   8'h01
`define CFC_RST_PALEN   16'h0000
`define CFC_RESP_OKAY   2'b00
`define CFC_RESP_SLVERR 2'b10

`endif

// ---- cfc_ed_model.sv ----
// execution device model behind the request and result streams
`timescale 1ns/1ps
module cfc_ed_model (
  // clock and reset
  input  logic        sys_clk,
  input  logic        rst_b,
  // request stream
  input  logic        edValid,
  output logic        edReady,
  input  logic [7:0]  edCmd,
  input  logic [31:0] edParam,
  input  logic [31:0] edData,
  // result stream
  output logic        resValid,
  output logic [31:0] resData,
  input  logic        resReady,
  // bench control and tallies
  input  logic        stall,
  output logic [31:0] reqCount,
  output logic [31:0] lastParam
);
  logic [31:0] resQ[$];

  // take words, answer pixel reads with word plus one, hold results until taken
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      edReady <= 1'b0;
      resValid <= 1'b0;
      reqCount <= '0;
      resQ.delete();
    end else begin
      edReady <= !stall;
      if (edValid && edReady) begin
        reqCount <= reqCount + 1;
        lastParam <= edParam;
        if (edCmd == 8'h01 || edCmd == 8'h02)
          resQ.push_back(edData + 32'h1);
      end
      if (resValid && !resReady) begin
        resValid <= 1'b1;
      end else if (resQ.size() > 0) begin
        resValid <= 1'b1;
        resData <= resQ.pop_front();
      end else begin
        resValid <= 1'b0;
        resData <= ~resData; // idle data never repeats the last word
      end
    end
  end
endmodule // cfc_ed_model

// ---- cfc_fifo.v ----
// queue with runtime depth limit built on the word memory
`timescale 1ns/1ps
module cfc_fifo #(
  parameter AW = 7
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // usable depth, at most 2**AW
  input  wire [AW:0] depthLimit,
  // fill side
  input  wire        pushEn,
  input  wire [31:0] pushData,
  // drain side
  input  wire        popEn,
  output wire [31:0] popData,
  // fill state
  output wire [AW:0] count,
  output wire        full,
  output wire        empty
);

  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0]   count_ff;
  wire         doPush;
  wire         doPop;

  // refuse rather than corrupt on overflow or underflow
  assign doPush = pushEn && !full;
  assign doPop  = popEn && !empty;
  assign count  = count_ff;
  assign full   = (count_ff >= depthLimit);
  assign empty  = (count_ff == {(AW+1){1'b0}});

  // pointers wrap at the physical size, the limit only caps the fill
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + 1'b1;
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  cfc_ram #(.AW(AW), .DW(32)) uRam (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wrEn    (doPush),
    .wrAddr  (wrPtr_ff),
    .wrData  (pushData),
    .rdEn    (doPop),
    .rdAddr  (rdPtr_ff),
    .rdData  (popData)
  );

endmodule // cfc_fifo

// ---- cfc_monitor.sv ----
// checker of bus and request stream rules
`timescale 1ns/1ps
`include "cfc_defs.vh"
module cfc_monitor (
  // clock and reset
  input logic        sys_clk,
  input logic        rst_b,
  // register bus
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // request stream and interrupt
  input logic        edValid,
  input logic        edReady,
  input logic [7:0]  edCmd,
  input logic [31:0] edData,
  input logic        irq
);
  // one domain, so one clock for all and one reset for all but chk_irq_reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  chk_ed_stall: assert property (edValid && !edReady |=> edValid && $stable(edData) && $stable(edCmd))
    else $error("request word lost while stalled");
  chk_nop_idle: assert property (edValid |-> edCmd != `CFC_CMD_NOP)
    else $error("request issued under no-op");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  chk_irq_reset: assert property (@(posedge sys_clk) disable iff (1'b0) !rst_b |=> !irq)
    else $error("interrupt after reset");

  cover property (edValid && edReady && edCmd == `CFC_CMD_RDPIX);
  cover property (edValid && !edReady);
  cover property (irq);
endmodule // cfc_monitor

bind cfc_cmd_flow cfc_monitor mon (.*);

// ---- cfc_ram.v ----
// word memory with registered read data for the queue ports
`timescale 1ns/1ps
module cfc_ram #(
  parameter AW = 7,
  parameter DW = 32
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          rst_b,
  // write side
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  // read side
  input  wire          rdEn,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // storage is left unreset, only the read register clears
  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // read data lands one cycle after the request
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      rdData <= {DW{1'b0}};
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule // cfc_ram

// ---- tb_cfc_cmd_flow.sv ----
// self-checking bench for the command flow controller
`timescale 1ns/1ps
`include "cfc_defs.vh"
module tb_cfc_cmd_flow;
  logic        sys_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, stall;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  resp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         edValid, edReady, resValid, resReady, irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [7:0]  edCmd;
  wire  [31:0] s_axi_rdata, edParam, edData, resData, reqCount, lastParam;
  int          bad_count = 0;
  int          comparisons = 0;

  cfc_cmd_flow #(.CHIP_SMALL(1)) dut (.*);
  cfc_ed_model ed (.*);

  // verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // sampled at the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ok = 0;
    int   n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!ok && n < 100) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      ok = s_axi_bvalid;
      resp = s_axi_bresp;
      n++;
    end
    if (!ok) begin
      bad_count++;
      test_done;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ok = 0;
    int   n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!ok && n < 100) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      ok = s_axi_rvalid;
      v = s_axi_rdata;
      resp = s_axi_rresp;
      n++;
    end
    if (!ok) begin
      bad_count++;
      test_done;
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rd(a, d);
    chk(nm, d, exp);
  endtask
  // poll a flag bit until set, as a host must before a new command
  task automatic waitFlag(input int b);
    int n = 0;
    d = '0;
    while (d[b] !== 1'b1 && n < 60) begin
      rd(`CFC_A_FLAGS, d);
      n++;
    end
    chk("flag", {31'h0, d[b]}, 32'h1);
    if (d[b] !== 1'b1) test_done;
  endtask
  task automatic waitEd(input logic [31:0] n);
    int k = 0;
    while (reqCount !== n && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    chk("ed words", reqCount, n);
    if (reqCount !== n) test_done;
  endtask
  task pushW(input logic [31:0] base, input int cnt);
    for (int i = 0; i < cnt; i++)
      wr(`CFC_A_INFIFO, base + i);
  endtask

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, stall} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rdchk(`CFC_A_FLAGS, 32'h13, "flags");
    chk("rd resp", {30'h0, resp}, 32'h0);
    rdchk(`CFC_A_REQCNT, 32'h0, "reqcnt");
    rdchk(`CFC_A_UPLIM, 32'h1, "uplim");
    wr(`CFC_A_SHADOW, 32'h5);
    chk("shadow wr resp", {30'h0, resp}, 32'h2);
    $display("test reset done");
    wr(`CFC_A_IRQMSK, 32'h1);
    wr(`CFC_A_PARAM, 32'h5a);
    wr(`CFC_A_CMD, `CFC_CMD_LINE);
    waitFlag(`CFC_F_CWE);
    chk("irq", {31'h0, irq}, 32'h1);
    rdchk(`CFC_A_IRQST, 32'h1, "irq status");
    chk("irq clr", {31'h0, irq}, 32'h0);
    pushW(32'h10, 3);
    waitEd(3);
    $display("test single transfer done");
    wr(`CFC_A_REQCNT, 32'h3);
    pushW(32'h20, 2);
    repeat (20) @(posedge sys_clk);
    chk("held words", reqCount, 32'h3);
    wr(`CFC_A_CMD, `CFC_CMD_NOP);
    waitEd(5);
    waitFlag(`CFC_F_CWE);
    rdchk(`CFC_A_SHADOW, 32'h0, "shadow");
    $display("test flush done");
    stall <= 1'b1;
    wr(`CFC_A_CMD, `CFC_CMD_LINE);
    waitFlag(`CFC_F_CWE);
    pushW(32'h30, 4);
    wr(`CFC_A_PARAM, 32'ha5);
    wr(`CFC_A_CMD, `CFC_CMD_LINE);
    rd(`CFC_A_FLAGS, d);
    chk("pipe full", {31'h0, d[0]}, 32'h0);
    stall <= 1'b0;
    waitEd(9);
    chk("old param", lastParam, 32'h5a);
    waitFlag(`CFC_F_CWE);
    pushW(32'h40, 4);
    waitEd(13);
    chk("new param", lastParam, 32'ha5);
    $display("test pipeline done");
    wr(`CFC_A_REQCNT, 32'h1);
    wr(`CFC_A_UPLIM, 32'h3);
    wr(`CFC_A_CMD, `CFC_CMD_RDPIX);
    waitFlag(`CFC_F_CWE);
    pushW(32'h100, 3);
    waitEd(15);
    rd(`CFC_A_FLAGS, d);
    chk("out high early", {31'h0, d[2]}, 32'h0);
    wr(`CFC_A_CMD, `CFC_CMD_NOP);
    waitEd(16);
    waitFlag(`CFC_F_OFH);
    for (int i = 0; i < 3; i++)
      rdchk(`CFC_A_OUTFIFO, 32'h101 + i, "result");
    wr(`CFC_A_PALEN, 32'h2);
    wr(`CFC_A_CMD, `CFC_CMD_RDPA);
    waitEd(18);
    $display("test read flow done");
    test_done;
  end
endmodule // tb_cfc_cmd_flow
